/* logic/secp_regs.vh */
// opcodes, status field positions and timing for the serial eeprom command and protect block
`ifndef SECP_REGS_VH
`define SECP_REGS_VH

// opcodes after masking bit 3
`define SECP_OP_MASK 8'hf7
`define SECP_OP_SET_LATCH 8'h06
`define SECP_OP_CLR_LATCH 8'h04
`define SECP_OP_STAT_RD 8'h05
`define SECP_OP_STAT_WR 8'h01
`define SECP_OP_ARRAY_RD 8'h03
`define SECP_OP_ARRAY_WR 8'h02

// write_protect_status field positions
`define SECP_ST_BUSY 0
`define SECP_ST_LATCH 1
`define SECP_ST_PROT_LO 2
`define SECP_ST_PROT_HI 3
`define SECP_ST_LOCK 7
`define SECP_ST_RESET 8'h00
`define SECP_ST_BUSY_VALUE 8'hff

// protection levels {hi, lo}
`define SECP_PROT_NONE 2'h0
`define SECP_PROT_QUARTER 2'h1
`define SECP_PROT_HALF 2'h2
`define SECP_PROT_ALL 2'h3

// self-timed write cycle
`define SECP_WRITE_TIME_US 5000
`define SECP_CLK_MHZ 100

`endif

/* logic/secp_top.v */
// command decoder, status register and write protection of a serial eeprom slave
// Contract
// - status register read-only if locked or latch clear
// - bit 0 busy; busy accepts only status read
// - latch clear blocks every status/array change
// - power-up clears the write latch
// - bits 2,3 protection, ship zero, 4 unused
// - bits 5,6 read zero unless busy
// - bit 7 with guard low locks status
// - lock clears only while guard pin high
// - busy status reads all ones
// - level table selects protected address range
// - protected locations never written
// - unprotected writable only with latch set
// - status write ignored unless latch, unlocked
// - latch and status read opcodes, bit3 ignored
// - status write, array read/write opcodes
// - sample rising, drive falling, msb first
// - chip select rise starts the operation
// - latch set/cleared by the listed commands
// - status read repeats while clocking
// - status write keeps levels, lock only
// - array read streams, wraps to zero
// - self-timed write ends within 5 ms
// - idle chip select high, output released
`include "secp_regs.vh"

module secp_top #(
    parameter ADDR_W = 16,
    parameter PAGE_W = 7,
    parameter WRITE_CYCLES = `SECP_WRITE_TIME_US * `SECP_CLK_MHZ
) (
    input wire clk,
    input wire rst,
    input wire cs_n,
    input wire sck,
    input wire si,
    input wire wp_n,
    output reg so,
    output reg so_oe
);

    // ****************************************
    // constants
    // ****************************************
    localparam PAGE_SIZE = 1 << PAGE_W;
    localparam ST_OPC = 3'd0;
    localparam ST_AHI = 3'd1;
    localparam ST_ALO = 3'd2;
    localparam ST_RD = 3'd3;
    localparam ST_WR = 3'd4;
    localparam ST_SR = 3'd5;
    localparam ST_SW = 3'd6;
    localparam ST_IGN = 3'd7;
    localparam P_NONE = 3'd0;
    localparam P_SET = 3'd1;
    localparam P_CLR = 3'd2;
    localparam P_SW = 3'd3;
    localparam P_WR = 3'd4;

    // ****************************************
    // storage
    // ****************************************
    reg [7:0] mem [0:(1 << ADDR_W) - 1]; // the array itself, no reset
    reg [7:0] pbuf [0:PAGE_SIZE - 1]; // page staging until deselect
    reg [PAGE_SIZE-1:0] pvalid; // which staged bytes were loaded

    // ****************************************
    // pin synchronisers
    // ****************************************
    reg [2:0] sck_q; // two sync flops plus one for edge finding
    reg [2:0] cs_q;
    reg [1:0] si_q;
    reg [1:0] wp_q;
    wire sck_rise = sck_q[1] & ~sck_q[2];
    wire sck_fall = ~sck_q[1] & sck_q[2];
    wire cs_n_s = cs_q[1];
    wire cs_rise = cs_q[1] & ~cs_q[2];
    wire si_s = si_q[1];
    wire wp_n_s = wp_q[1];

    // the second flop of each chain feeds logic; the third of sck and cs feeds edge finding
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sck_q <= 3'h0;
            cs_q <= 3'h7; // deselected at power-up
            si_q <= 2'h0;
            wp_q <= 2'h3;
        end
        else
        begin
            sck_q <= {sck_q[1:0], sck};
            cs_q <= {cs_q[1:0], cs_n};
            si_q <= {si_q[0], si};
            wp_q <= {wp_q[0], wp_n};
        end
    end

    // ****************************************
    // control state
    // ****************************************
    reg [2:0] state; // serial decode state
    reg [2:0] pend; // operation to start on deselect
    reg [2:0] bit_cnt; // bit position within the byte
    reg [6:0] rx_sh; // bits of the byte in flight
    reg [7:0] tx_sh; // byte being shifted out
    reg [ADDR_W-1:0] addr; // running array address
    reg [7:0] sw_data; // status write byte, held until cycle end
    reg rd_mode; // address phase belongs to a read
    reg wel; // write latch
    reg prot_lo; // protection level bits, kept across commands
    reg prot_hi;
    reg lock; // status lock enable
    reg wbusy; // internal write cycle running
    reg wkind_stat; // cycle writes status rather than array
    reg [31:0] wtimer; // self-timed cycle counter
    reg [PAGE_W:0] widx; // commit walk through the page

    wire [7:0] rx_next = {rx_sh, si_s};
    wire [7:0] op = rx_next & `SECP_OP_MASK; // bit 3 is don't care
    wire byte_done = ~cs_n_s & sck_rise & (bit_cnt == 3'd7);
    wire hw_prot = lock & ~wp_n_s;
    wire [1:0] level = {prot_hi, prot_lo};

    // busy forces all ones, bits 4..6 otherwise zero
    wire [7:0] status_rd = wbusy ? `SECP_ST_BUSY_VALUE :
        {lock, 3'b000, prot_hi, prot_lo, wel, 1'b0};

    // true when the address falls in the selected protected range
    function prot_hit;
        input [1:0] lvl;
        input [ADDR_W-1:0] a;
        begin
            case (lvl)
                `SECP_PROT_QUARTER: prot_hit = &a[ADDR_W-1:ADDR_W-2];
                `SECP_PROT_HALF: prot_hit = a[ADDR_W-1];
                `SECP_PROT_ALL: prot_hit = 1'b1;
                default: prot_hit = 1'b0;
            endcase
        end
    endfunction

    // ****************************************
    // array and page writes
    // ****************************************
    wire [PAGE_W-1:0] wslot = widx[PAGE_W-1:0];
    wire [ADDR_W-1:0] waddr = {addr[ADDR_W-1:PAGE_W], wslot};
    // walk the page, skipping unloaded and protected bytes
    wire commit_we = wbusy & ~wkind_stat & ~widx[PAGE_W] & pvalid[wslot] & ~prot_hit(level, waddr);
    wire pb_we = byte_done & (state == ST_WR);

    // the array only changes through the commit walk; later page bytes overwrite a slot
    always @(posedge clk)
    begin
        if (commit_we)
            mem[waddr] <= pbuf[wslot];
        if (pb_we)
            pbuf[addr[PAGE_W-1:0]] <= rx_next;
    end

    // ****************************************
    // serial decode, latch, status and write cycle
    // ****************************************
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_OPC;
            pend <= P_NONE;
            bit_cnt <= 3'd0;
            rx_sh <= 7'h00;
            tx_sh <= 8'h00;
            addr <= {ADDR_W{1'b0}};
            sw_data <= 8'h00;
            rd_mode <= 1'b0;
            wel <= 1'b0;
            prot_lo <= 1'b0;
            prot_hi <= 1'b0;
            lock <= 1'b0;
            wbusy <= 1'b0;
            wkind_stat <= 1'b0;
            wtimer <= 32'h0000_0000;
            widx <= {(PAGE_W + 1){1'b0}};
            pvalid <= {PAGE_SIZE{1'b0}};
            so <= 1'b0;
            so_oe <= 1'b0;
        end
        else
        begin
            // self-timed cycle, bounded by the timer
            if (wbusy)
            begin
                if (~widx[PAGE_W])
                    widx <= widx + 1'b1;
                if (wtimer == WRITE_CYCLES - 1)
                begin
                    wbusy <= 1'b0;
                    wel <= 1'b0;
                    if (wkind_stat)
                    begin
                        // only levels and lock are stored, at cycle end
                        prot_lo <= sw_data[`SECP_ST_PROT_LO];
                        prot_hi <= sw_data[`SECP_ST_PROT_HI];
                        if (sw_data[`SECP_ST_LOCK] | ~lock | wp_n_s)
                            lock <= sw_data[`SECP_ST_LOCK];
                    end
                end
                else
                    wtimer <= wtimer + 32'h0000_0001;
            end

            if (cs_n_s)
            begin
                // deselected: release output, start the pending operation
                state <= ST_OPC;
                bit_cnt <= 3'd0;
                so_oe <= 1'b0;
                pend <= P_NONE;
                // a partial trailing byte voids the operation
                if (cs_rise && bit_cnt == 3'd0 && !wbusy)
                begin
                    case (pend)
                        P_SET: wel <= 1'b1;
                        P_CLR: wel <= 1'b0;
                        P_SW, P_WR:
                        begin
                            // the guard pin only refuses status writes, never the array
                            if (wel & ~((pend == P_SW) & hw_prot))
                            begin
                                wbusy <= 1'b1;
                                wkind_stat <= (pend == P_SW);
                                wtimer <= 32'h0000_0000;
                                widx <= {(pend == P_SW), {PAGE_W{1'b0}}}; // status write skips the page walk
                            end
                        end
                        default: ;
                    endcase
                end
            end
            else if (sck_rise)
            begin
                // sample on rising edges, msb first
                bit_cnt <= bit_cnt + 3'd1;
                rx_sh <= rx_next[6:0];
                if (bit_cnt == 3'd7)
                begin
                    case (state)
                        ST_OPC:
                        begin
                            // refused and unknown opcodes park in the ignore state
                            state <= ST_IGN;
                            if (!wbusy || op == `SECP_OP_STAT_RD)
                            begin
                                case (op)
                                    `SECP_OP_SET_LATCH: pend <= P_SET;
                                    `SECP_OP_CLR_LATCH: pend <= P_CLR;
                                    `SECP_OP_STAT_RD:
                                    begin
                                        tx_sh <= status_rd;
                                        state <= ST_SR;
                                    end
                                    `SECP_OP_STAT_WR: state <= ST_SW;
                                    `SECP_OP_ARRAY_RD:
                                    begin
                                        rd_mode <= 1'b1;
                                        state <= ST_AHI;
                                    end
                                    `SECP_OP_ARRAY_WR:
                                    begin
                                        rd_mode <= 1'b0;
                                        pvalid <= {PAGE_SIZE{1'b0}};
                                        state <= ST_AHI;
                                    end
                                    default: ;
                                endcase
                            end
                        end
                        ST_AHI:
                        begin
                            addr[ADDR_W-1:8] <= rx_next[ADDR_W-9:0];
                            state <= ST_ALO;
                        end
                        ST_ALO:
                        begin
                            if (rd_mode)
                            begin
                                tx_sh <= mem[{addr[ADDR_W-1:8], rx_next}];
                                addr <= {addr[ADDR_W-1:8], rx_next} + 1'b1;
                                state <= ST_RD;
                            end
                            else
                            begin
                                addr[7:0] <= rx_next;
                                state <= ST_WR;
                            end
                        end
                        ST_RD:
                        begin
                            // natural overflow wraps the last address to zero
                            tx_sh <= mem[addr];
                            addr <= addr + 1'b1;
                        end
                        ST_SR: tx_sh <= status_rd;
                        ST_SW:
                        begin
                            sw_data <= rx_next;
                            pend <= P_SW;
                            state <= ST_IGN;
                        end
                        ST_WR:
                        begin
                            // address wraps inside the page
                            pvalid[addr[PAGE_W-1:0]] <= 1'b1;
                            addr[PAGE_W-1:0] <= addr[PAGE_W-1:0] + 1'b1;
                            pend <= P_WR;
                        end
                        default: ; // extra bytes are ignored
                    endcase
                end
            end
            else if (sck_fall && (state == ST_RD || state == ST_SR))
            begin
                // drive on falling edges, msb first
                so <= tx_sh[7];
                tx_sh <= {tx_sh[6:0], 1'b0};
                so_oe <= 1'b1;
            end
        end
    end

endmodule

/* bench/secp_top_chk.sv */
// assertions on the serial pins of the eeprom command and protect block
module secp_top_chk (
    input wire clk,
    input wire rst,
    input wire cs_n,
    input wire sck,
    input wire si,
    input wire wp_n,
    input wire so,
    input wire so_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // sck fall history
    // ****************
    logic sck_q; // sck as seen one edge ago
    logic [4:0] fell_sh; // bit n: a pin fall seen n+1 edges back
    // history of falls, so output moves can be tied to a cause
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sck_q <= 1'b0;
            fell_sh <= 5'h00;
        end
        else
        begin
            sck_q <= sck;
            fell_sh <= {fell_sh[3:0], sck_q & ~sck};
        end
    end
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // reset holds the output quiet; first edge ignored as regs may still be unknown
    AST_RESET_QUIET: assert property (disable iff (1'b0) rst && $past(rst) |-> !so && !so_oe)
        else $error("output active in reset");
    AST_IDLE_RELEASE: assert property (cs_n [*4] |-> !so_oe)
        else $error("output enabled while deselected");
    AST_SO_AFTER_FALL: assert property ($changed(so) |-> |fell_sh[4:1])
        else $error("data out moved without a clock fall");
    AST_OE_RISE_ON_FALL: assert property ($rose(so_oe) |-> |fell_sh[4:1] && !cs_n)
        else $error("enable rose off a falling clock");
    AST_OE_DROP_ON_DESELECT: assert property ($fell(so_oe) |-> $past(cs_n, 2))
        else $error("enable dropped while selected");
    AST_OE_NEEDS_SELECT: assert property (so_oe |-> !$past(cs_n, 4))
        else $error("enable held long after deselect");
    AST_SO_IDLE_STABLE: assert property (cs_n [*6] |-> $stable(so))
        else $error("data out moved while idle");
    AST_OE_HOLDS: assert property (so_oe && !cs_n |=> so_oe)
        else $error("enable lost within a frame");
    COV_OUT_ON: cover property ($rose(so_oe));
    COV_OUT_OFF: cover property ($fell(so_oe));
    COV_ONE_OUT: cover property (so_oe && so);
endmodule

bind secp_top secp_top_chk chk (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
    .wp_n(wp_n), .so(so), .so_oe(so_oe));

/* bench/secp_spi_mst.sv */
// bus master model that drives the eeprom block's serial link
module secp_spi_mst (
    input wire clk,
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire so
);
    timeunit 1ns;
    timeprecision 1ns;
    // deselected, clock parked low until the first frame
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // one byte msb first, 80 ns a bit; so read on the same edge that raises sck
    task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge clk);
            cs_n <= 1'b0;
            sck <= 1'b0;
            si <= tx[i];
            repeat (5) @(posedge clk);
            rx[i] = so;
            sck <= 1'b1;
            repeat (2) @(posedge clk);
        end
    endtask
    // drop the clock, then deselect before any further rise
    task automatic fin;
        @(posedge clk);
        sck <= 1'b0;
        repeat (5) @(posedge clk);
        cs_n <= 1'b1;
        si <= ~si; // no stale level once deselected
        repeat (6) @(posedge clk);
    endtask
endmodule

/* bench/secp_top_tb.sv */
// self-checking bench of the eeprom command and protect block
`include "secp_regs.vh"
module secp_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wp_n = 1'b1; // write guard released
    logic cs_n, sck, si, so, so_oe;
    logic [7:0] st, b; // status and scratch
    logic [15:0] adr [6] = '{16'h0000, 16'h7fff, 16'h8000, 16'hbfff, 16'hc000, 16'hffff};
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    // short write cycle keeps the run brief
    localparam int WCYC = 400;
    // a released output shows the opposite of its last bit, so a stale sample cannot pass
    wire so_pin = so_oe ? so : ~so;
    secp_top #(.WRITE_CYCLES(WCYC)) dut (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
        .wp_n(wp_n), .so(so), .so_oe(so_oe));
    secp_spi_mst mst (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so_pin));
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        n_checks++;
        if (got !== want)
        begin
            errors++;
            $display("BAD t=%0t got=%h want=%h", $time, got, want);
        end
    endtask
    task automatic op(input logic [7:0] c);
        mst.xb(c, b);
        mst.fin();
    endtask
    task automatic status_read_cmd(output logic [7:0] s);
        mst.xb(`SECP_OP_STAT_RD, b);
        mst.xb(8'h00, s);
        mst.fin();
    endtask
    // poll until ready, then read once more as the first value may be misplaced
    task automatic ready;
        for (int i = 0; i < 40; i++)
        begin
            status_read_cmd(st);
            if (st[0] === 1'b0)
                break;
        end
        status_read_cmd(st);
    endtask
    task automatic status_write_cmd(input logic [7:0] v, input logic en);
        if (en)
            op(`SECP_OP_SET_LATCH);
        mst.xb(`SECP_OP_STAT_WR, b);
        mst.xb(v, b);
        mst.fin();
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic en);
        if (en)
            op(`SECP_OP_SET_LATCH);
        mst.xb(`SECP_OP_ARRAY_WR, b);
        mst.xb(a[15:8], b);
        mst.xb(a[7:0], b);
        mst.xb(d, b);
        mst.fin();
        ready();
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d0, output logic [7:0] d1);
        mst.xb(`SECP_OP_ARRAY_RD, b);
        mst.xb(a[15:8], b);
        mst.xb(a[7:0], b);
        mst.xb(8'h00, d0);
        mst.xb(8'h00, d1);
        mst.fin();
    endtask
    task automatic t_reset;
        status_read_cmd(st);
        chk(st, `SECP_ST_RESET);
        chk({7'h00, so_oe}, 8'h00);
    endtask
    // latch opcodes with bit 3 clear and set, then a repeating status read
    task automatic t_latch;
        logic [7:0] c [4] = '{8'h06, 8'h04, 8'h0e, 8'h0c};
        for (int i = 0; i < 4; i++)
        begin
            op(c[i]);
            status_read_cmd(st);
            chk(st, {6'h00, ~i[0], 1'b0});
        end
        op(`SECP_OP_SET_LATCH);
        mst.xb(8'h0d, b);
        mst.xb(8'h00, st);
        mst.xb(8'h00, b);
        mst.fin();
        chk(st, 8'h02);
        chk(b, 8'h02);
        op(`SECP_OP_CLR_LATCH);
    endtask
    // status write: refused without latch, busy reads ones, only 2,3,7 kept
    task automatic t_stwr;
        status_write_cmd(8'hff, 1'b0);
        status_read_cmd(st);
        chk(st, 8'h00);
        status_write_cmd(8'hf3, 1'b1);
        op(`SECP_OP_SET_LATCH); // refused while busy
        status_read_cmd(st);
        chk(st, `SECP_ST_BUSY_VALUE);
        ready();
        chk(st, 8'h80);
    endtask
    // guard low with lock set: status frozen, array still writable
    task automatic t_lock;
        @(posedge clk);
        wp_n <= 1'b0;
        status_write_cmd(8'h0c, 1'b1);
        ready();
        chk(st, 8'h82);
        wr(16'h1234, 8'h5a, 1'b0);
        chk(st, 8'h80);
        rd(16'h1234, b, st);
        chk(b, 8'h5a);
        @(posedge clk);
        wp_n <= 1'b1;
        status_write_cmd(8'h00, 1'b1);
        // wait out the write time instead of polling
        repeat (WCYC) @(posedge clk);
        status_read_cmd(st);
        chk(st, 8'h00);
    endtask
    // every protection level against boundary addresses, then wrapping read
    task automatic t_prot;
        logic [7:0] e [6];
        logic [7:0] d0, d1;
        for (int l = 0; l < 4; l++)
        begin
            status_write_cmd({4'h0, l[1:0], 2'h0}, 1'b1);
            ready();
            chk(st, {4'h0, l[1:0], 2'h0});
            for (int k = 0; k < 6; k++)
            begin
                wr(adr[k], {l[3:0], k[3:0]}, 1'b1);
                if (l == 0 || (l == 1 && adr[k] < 16'hc000) || (l == 2 && adr[k] < 16'h8000))
                    e[k] = {l[3:0], k[3:0]};
                rd(adr[k], d0, d1);
                chk(d0, e[k]);
            end
        end
        status_write_cmd(8'h00, 1'b1);
        ready();
        wr(16'h0000, 8'h77, 1'b0);
        rd(16'hffff, d0, d1);
        chk(d0, e[5]);
        chk(d1, e[0]);
    endtask
    // undefined opcode voids the rest of its frame
    task automatic t_bad;
        mst.xb(8'h07, b);
        mst.xb(`SECP_OP_SET_LATCH, b);
        mst.fin();
        status_read_cmd(st);
        chk(st, 8'h00);
    endtask
    task automatic final_report;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            errors++;
            final_report();
        end
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_latch();
        t_stwr();
        t_lock();
        t_prot();
        t_bad();
        final_report();
    end
endmodule
